/* core/dma_device_end.sv */
/*
  Channel table controller: table fetch, peripheral scatter-gather,
  basic cycles, done pulses and bus error handling.
  Assumes the host end answers each memory access with ack or err.
*/
`timescale 1ns/100ps
module dma_device_end #(
  parameter int CH_N = dma_pkg::CH_N
) (
  input  wire logic  CLK_I,
  input  wire logic  RST_I,
  dma_link_if.device LINK,
  output logic       ACTIVE_O
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (CH_N < 1 || CH_N > (1 << dma_pkg::CH_W)) begin : g_bad_ch
    $error("CH_N must lie between 1 and 8");
  end

  typedef enum logic [2:0] {
    S_ARB, S_RD_SRC, S_RD_DST, S_RD_CFG, S_XFER_RD, S_XFER_WR, S_WB_CFG
  } state_t;

  state_t          state_r;
  logic [31:0]     base_r;
  logic [CH_N-1:0] chen_r;
  logic [CH_N-1:0] chen_nxt;
  logic [CH_N-1:0] alt_sel_r;
  logic [CH_N-1:0] alt_sel_nxt;
  logic [CH_N-1:0] done_r;
  logic            err_r;
  logic [2:0]      ch_r;
  logic            alt_r;
  logic            copy_r;
  logic [31:0]     src_r;
  logic [31:0]     dst_r;
  logic [31:0]     cfg_r;
  logic [31:0]     data_r;
  logic [10:0]     rem_r;
  logic [10:0]     grp_r;
  logic [1:0]      k_r;
  logic [2:0]      pick;
  logic            found;

  // ****************************************
  // Arbitration, lowest channel wins
  // ****************************************
  always_comb begin
    found = 1'b0;
    pick  = 3'h0;
    for (int i = CH_N - 1; i >= 0; i--) begin
      if (chen_r[i] && LINK.dma_req[i]) begin
        found = 1'b1;
        pick  = 3'(i);
      end
    end
  end

  // ****************************************
  // Decode of fetched and current fields
  // ****************************************
  wire [2:0]  rd_mode  = LINK.mem_rdata[dma_pkg::MODE_LSB +: dma_pkg::MODE_W];
  wire [9:0]  rd_n     = LINK.mem_rdata[dma_pkg::N_LSB +: dma_pkg::N_W];
  wire [3:0]  rd_rp    = LINK.mem_rdata[dma_pkg::RP_LSB +: dma_pkg::RP_W];
  wire [2:0]  cur_mode = cfg_r[dma_pkg::MODE_LSB +: dma_pkg::MODE_W];
  wire [10:0] grp_load = (rd_rp >= dma_pkg::RP_CAP) ? 11'h400 :
                         (11'h001 << rd_rp);
  wire [10:0] rem_m1   = rem_r - 11'h001;
  wire [31:0] back     = {19'h00000, rem_m1, 2'b00};
  wire        ack      = LINK.mem_ack && state_r != S_ARB;
  wire        bus_err  = LINK.mem_err && state_r != S_ARB;
  wire        skip_wr  = copy_r && k_r == dma_pkg::COPY_SKIP_K;
  wire        last_xfr = rem_r == 11'h001 || grp_r == 11'h001;
  wire        cfg_stop = ack && state_r == S_RD_CFG &&
                         rd_mode == dma_pkg::MODE_STOP;
  wire        wb_done  = ack && state_r == S_WB_CFG;
  wire        task_end = wb_done && !copy_r && rem_r == 11'h000;
  wire        fin_done = task_end && cur_mode != dma_pkg::MODE_PSG_ALT;
  wire [CH_N-1:0] ch_oh = CH_N'(1) << ch_r;

  // ****************************************
  // Table and data addressing
  // ****************************************
  wire [3:0]  elem     = (state_r == S_RD_SRC) ? dma_pkg::OFS_SRC :
                         (state_r == S_RD_DST) ? dma_pkg::OFS_DST :
                         dma_pkg::OFS_CFG;
  wire [31:0] tbl_addr = {base_r[31:dma_pkg::ALIGN_W], alt_r, ch_r,
                          elem};
  wire [31:0] cpy_addr = {base_r[31:dma_pkg::ALIGN_W], 1'b1, ch_r, k_r,
                          2'b00};
  wire [31:0] src_addr = src_r - back;
  wire [31:0] dst_addr = copy_r ? cpy_addr : dst_r - back;
  wire [9:0]  n_new    = (rem_r == 11'h000) ? 10'h000 : rem_m1[9:0];
  wire [2:0]  mode_new = (rem_r == 11'h000) ? dma_pkg::MODE_STOP :
                         cur_mode;
  wire [31:0] cfg_new  = {cfg_r[31:dma_pkg::RP_LSB], n_new,
                          cfg_r[dma_pkg::UB_BIT], mode_new};

  assign LINK.mem_req   = state_r != S_ARB;
  assign LINK.mem_we    = state_r == S_XFER_WR ||
                          state_r == S_WB_CFG;
  assign LINK.mem_addr  = (state_r == S_XFER_RD) ? src_addr :
                          (state_r == S_XFER_WR) ? dst_addr : tbl_addr;
  assign LINK.mem_wdata = (state_r == S_WB_CFG) ? cfg_new : data_r;
  assign LINK.dma_done  = done_r;
  assign LINK.dma_err   = err_r;
  assign ACTIVE_O       = state_r != S_ARB;

  // ****************************************
  // Register port
  // ****************************************
  wire        wr_base = LINK.reg_we && LINK.reg_addr == dma_pkg::REG_PRI_BASE;
  wire        wr_set  = LINK.reg_we && LINK.reg_addr == dma_pkg::REG_CHEN_SET;
  wire        wr_clr  = LINK.reg_we && LINK.reg_addr == dma_pkg::REG_CHEN_CLR;
  wire        wr_err  = LINK.reg_we && LINK.reg_addr == dma_pkg::REG_ERR;
  wire [31:0] pri_rd  = {base_r[31:dma_pkg::ALIGN_W], 8'h00};
  wire [31:0] alt_rd  = {base_r[31:dma_pkg::ALIGN_W],
                         dma_pkg::ALT_OFFSET};
  wire [31:0] chen_rd = 32'(chen_r);

  assign LINK.reg_rdata =
    (LINK.reg_addr == dma_pkg::REG_PRI_BASE) ? pri_rd  :
    (LINK.reg_addr == dma_pkg::REG_ALT_BASE) ? alt_rd  :
    (LINK.reg_addr == dma_pkg::REG_CHEN_SET ||
     LINK.reg_addr == dma_pkg::REG_CHEN_CLR) ? chen_rd :
    (LINK.reg_addr == dma_pkg::REG_ERR)      ? {31'h00000000, err_r} :
    32'h00000000;

  // ****************************************
  // Channel enable and structure select
  // ****************************************
  wire kill_en = bus_err || fin_done ||
                 (cfg_stop && !alt_r);
  wire alt_clr = bus_err || task_end || (cfg_stop && alt_r);
  wire alt_set = wb_done && copy_r;

  assign chen_nxt = (chen_r | (wr_set ? LINK.reg_wdata[CH_N-1:0] : '0)) &
                    ~(wr_clr ? LINK.reg_wdata[CH_N-1:0] : '0) &
                    ~(kill_en ? ch_oh : '0);
  assign alt_sel_nxt = (alt_sel_r | (alt_set ? ch_oh : '0)) &
                       ~(alt_clr ? ch_oh : '0);

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      base_r    <= 32'h00000000;
      chen_r    <= '0;
      alt_sel_r <= '0;
      done_r    <= '0;
      err_r     <= 1'b0;
    end else begin
      if (wr_base) begin
        base_r <= LINK.reg_wdata;
      end
      chen_r    <= chen_nxt;
      alt_sel_r <= alt_sel_nxt;
      done_r    <= fin_done ? ch_oh : '0;
      err_r     <= bus_err || (err_r && !wr_err);
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_r <= S_ARB;
      ch_r    <= 3'h0;
      alt_r   <= 1'b0;
      copy_r  <= 1'b0;
      src_r   <= 32'h00000000;
      dst_r   <= 32'h00000000;
      cfg_r   <= 32'h00000000;
      data_r  <= 32'h00000000;
      rem_r   <= 11'h000;
      grp_r   <= 11'h000;
      k_r     <= 2'h0;
    end else if (bus_err) begin
      state_r <= S_ARB;
    end else begin
      unique case (state_r)
        S_ARB: begin
          if (found) begin
            ch_r    <= pick;
            alt_r   <= alt_sel_r[pick];
            state_r <= S_RD_SRC;
          end
        end
        S_RD_SRC: begin
          if (ack) begin
            src_r   <= LINK.mem_rdata;
            state_r <= S_RD_DST;
          end
        end
        S_RD_DST: begin
          if (ack) begin
            dst_r   <= LINK.mem_rdata;
            state_r <= S_RD_CFG;
          end
        end
        S_RD_CFG: begin
          if (ack) begin
            cfg_r  <= LINK.mem_rdata;
            rem_r  <= {1'b0, rd_n} + 11'h001;
            k_r    <= 2'h0;
            copy_r <= !alt_r && rd_mode == dma_pkg::MODE_PSG_PRI;
            grp_r  <= (!alt_r && rd_mode == dma_pkg::MODE_PSG_PRI) ?
                      dma_pkg::COPY_XFERS : grp_load;
            state_r <= cfg_stop ? S_ARB : S_XFER_RD;
          end
        end
        S_XFER_RD: begin
          if (ack) begin
            data_r <= LINK.mem_rdata;
            if (skip_wr) begin
              rem_r   <= rem_m1;
              grp_r   <= grp_r - 11'h001;
              k_r     <= k_r + 2'h1;
              state_r <= last_xfr ? S_WB_CFG : S_XFER_RD;
            end else begin
              state_r <= S_XFER_WR;
            end
          end
        end
        S_XFER_WR: begin
          if (ack) begin
            rem_r   <= rem_m1;
            grp_r   <= grp_r - 11'h001;
            k_r     <= k_r + 2'h1;
            state_r <= last_xfr ? S_WB_CFG : S_XFER_RD;
          end
        end
        S_WB_CFG: begin
          if (ack) begin
            if (copy_r) begin
              alt_r   <= 1'b1;
              copy_r  <= 1'b0;
              state_r <= S_RD_SRC;
            end else begin
              state_r <= S_ARB;
            end
          end
        end
      endcase
    end
  end

endmodule : dma_device_end

/* core/dma_pkg.sv */
/*
  Shared constants of the channel table controller and its host end.
  Assumes a 32-bit word memory and at most eight channels.
*/
package dma_pkg;

  // ****************************************
  // Table layout
  // ****************************************
  localparam int          CH_N        = 8;
  localparam int          CH_W        = 3;
  localparam int          TABLE_BYTES = 256;
  localparam int          ALIGN_W     = 8;
  localparam int          ALT_BIT     = 7;
  localparam int          CH_LSB      = 4;
  localparam logic [3:0]  OFS_SRC     = 4'h0;
  localparam logic [3:0]  OFS_DST     = 4'h4;
  localparam logic [3:0]  OFS_CFG     = 4'h8;
  localparam logic [3:0]  OFS_UNUSED  = 4'hC;
  localparam logic [7:0]  ALT_OFFSET  = 8'h80;

  // ****************************************
  // Configuration word fields
  // ****************************************
  localparam int          MODE_LSB    = 0;
  localparam int          MODE_W      = 3;
  localparam int          UB_BIT      = 3;
  localparam int          N_LSB       = 4;
  localparam int          N_W         = 10;
  localparam int          RP_LSB      = 14;
  localparam int          RP_W        = 4;
  localparam logic [3:0]  RP_CAP      = 4'hA;
  localparam logic [2:0]  MODE_STOP   = 3'h0;
  localparam logic [2:0]  MODE_BASIC  = 3'h1;
  localparam logic [2:0]  MODE_PSG_PRI = 3'h6;
  localparam logic [2:0]  MODE_PSG_ALT = 3'h7;
  localparam logic [10:0] COPY_XFERS  = 11'h004;
  localparam logic [1:0]  COPY_SKIP_K = 2'h3;

  // ****************************************
  // Device register indices
  // ****************************************
  localparam logic [2:0]  REG_PRI_BASE = 3'h0;
  localparam logic [2:0]  REG_ALT_BASE = 3'h1;
  localparam logic [2:0]  REG_CHEN_SET = 3'h2;
  localparam logic [2:0]  REG_CHEN_CLR = 3'h3;
  localparam logic [2:0]  REG_ERR      = 3'h4;

  // ****************************************
  // Host software map
  // ****************************************
  localparam int          MEM_WORDS    = 1024;
  localparam int          REG_SEL_BIT  = 12;
  localparam logic [3:0]  IDX_DEV_LAST = 4'h4;
  localparam logic [3:0]  IDX_DONE_REC = 4'h8;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage : dma_pkg

/* core/dma_link_if.sv */
/*
  Link between the table controller and its host end.
  Assumes both ends run on one common clock.
*/
`timescale 1ns/100ps
interface dma_link_if #(parameter int CH_N = dma_pkg::CH_N);
  logic            reg_we;
  logic            reg_re;
  logic [2:0]      reg_addr;
  logic [31:0]     reg_wdata;
  logic [31:0]     reg_rdata;
  logic            mem_req;
  logic            mem_we;
  logic [31:0]     mem_addr;
  logic [31:0]     mem_wdata;
  logic [31:0]     mem_rdata;
  logic            mem_ack;
  logic            mem_err;
  logic [CH_N-1:0] dma_req;
  logic [CH_N-1:0] dma_done;
  logic            dma_err;

  modport device (
    input  reg_we, reg_re, reg_addr, reg_wdata, mem_rdata, mem_ack,
    input  mem_err, dma_req,
    output reg_rdata, mem_req, mem_we, mem_addr, mem_wdata, dma_done,
    output dma_err
  );
  modport host (
    output reg_we, reg_re, reg_addr, reg_wdata, mem_rdata, mem_ack,
    output mem_err, dma_req,
    input  reg_rdata, mem_req, mem_we, mem_addr, mem_wdata, dma_done,
    input  dma_err
  );
endinterface : dma_link_if

/* core/dma_host_end.sv */
/*
  Host end: table and data memory, AXI4-Lite slave for software,
  done record and forwarding of device register accesses.
  Assumes one outstanding AXI write and one read at a time.
*/
`timescale 1ns/100ps
module dma_host_end #(
  parameter int CH_N      = dma_pkg::CH_N,
  parameter int MEM_WORDS = dma_pkg::MEM_WORDS
) (
  input  wire logic            CLK_I,
  input  wire logic            RST_I,
  dma_link_if.host             LINK,
  input  wire logic [31:0]     AWADDR_I,
  input  wire logic            AWVALID_I,
  output logic                 AWREADY_O,
  input  wire logic [31:0]     WDATA_I,
  input  wire logic [3:0]      WSTRB_I,
  input  wire logic            WVALID_I,
  output logic                 WREADY_O,
  output logic [1:0]           BRESP_O,
  output logic                 BVALID_O,
  input  wire logic            BREADY_I,
  input  wire logic [31:0]     ARADDR_I,
  input  wire logic            ARVALID_I,
  output logic                 ARREADY_O,
  output logic [31:0]          RDATA_O,
  output logic [1:0]           RRESP_O,
  output logic                 RVALID_O,
  input  wire logic            RREADY_I,
  input  wire logic [CH_N-1:0] PERIPH_REQ_I,
  output logic                 ERR_O
);

  // ****************************************
  // Parameter check
  // ****************************************
  localparam int MEM_AW = $clog2(MEM_WORDS);
  if (MEM_WORDS < 64 || (1 << MEM_AW) != MEM_WORDS ||
      MEM_AW > dma_pkg::REG_SEL_BIT - 2) begin : g_bad_mem
    $error("MEM_WORDS must be a power of two from 64 to 1024");
  end

  logic [31:0]     mem_r [MEM_WORDS];
  logic            aw_got_r;
  logic [31:0]     awaddr_r;
  logic            w_got_r;
  logic [31:0]     wdata_r;
  logic [3:0]      wstrb_r;
  logic            bvalid_r;
  logic [1:0]      bresp_r;
  logic            rvalid_r;
  logic [1:0]      rresp_r;
  logic [31:0]     rdata_r;
  logic [CH_N-1:0] done_rec_r;
  logic            ack_r;
  logic            merr_r;
  logic [31:0]     mrdata_r;
  logic [31:0]     wmerged;

  // ****************************************
  // Software address decode
  // ****************************************
  wire        wr_go   = aw_got_r && w_got_r && !bvalid_r;
  wire        rd_go   = ARVALID_I && ARREADY_O;
  wire        w_isreg = awaddr_r[dma_pkg::REG_SEL_BIT];
  wire [3:0]  w_idx   = awaddr_r[5:2];
  wire        w_dev   = w_isreg && w_idx <= dma_pkg::IDX_DEV_LAST;
  wire        w_rec   = w_isreg && w_idx == dma_pkg::IDX_DONE_REC;
  wire        w_mem   = !w_isreg && awaddr_r[31:dma_pkg::REG_SEL_BIT+1] == '0;
  wire        r_isreg = ARADDR_I[dma_pkg::REG_SEL_BIT];
  wire [3:0]  r_idx   = ARADDR_I[5:2];
  wire        r_dev   = r_isreg && r_idx <= dma_pkg::IDX_DEV_LAST;
  wire        r_rec   = r_isreg && r_idx == dma_pkg::IDX_DONE_REC;
  wire        r_mem   = !r_isreg && ARADDR_I[31:dma_pkg::REG_SEL_BIT+1] == '0;
  wire        axi_mwr = wr_go && w_mem;
  wire [MEM_AW-1:0] w_word = awaddr_r[MEM_AW+1:2];
  wire [MEM_AW-1:0] r_word = ARADDR_I[MEM_AW+1:2];

  always_comb begin
    wmerged = mem_r[w_word];
    for (int b = 0; b < 4; b++) begin
      if (wstrb_r[b]) begin
        wmerged[8*b +: 8] = wdata_r[8*b +: 8];
      end
    end
  end

  assign AWREADY_O      = !aw_got_r && !bvalid_r;
  assign WREADY_O       = !w_got_r && !bvalid_r;
  assign ARREADY_O      = !rvalid_r && !wr_go;
  assign BVALID_O       = bvalid_r;
  assign BRESP_O        = bresp_r;
  assign RVALID_O       = rvalid_r;
  assign RRESP_O        = rresp_r;
  assign RDATA_O        = rdata_r;
  assign LINK.reg_we    = wr_go && w_dev;
  assign LINK.reg_re    = rd_go && r_dev;
  assign LINK.reg_addr  = wr_go ? w_idx[2:0] : r_idx[2:0];
  assign LINK.reg_wdata = wdata_r;
  assign LINK.dma_req   = PERIPH_REQ_I;
  assign ERR_O          = LINK.dma_err;

  // ****************************************
  // Memory port towards the controller
  // ****************************************
  wire in_range = LINK.mem_addr[31:MEM_AW+2] == '0;
  wire serve    = LINK.mem_req && !ack_r && !merr_r && !axi_mwr;
  wire [MEM_AW-1:0] m_word = LINK.mem_addr[MEM_AW+1:2];

  assign LINK.mem_ack   = ack_r;
  assign LINK.mem_err   = merr_r;
  assign LINK.mem_rdata = mrdata_r;

  always_ff @(posedge CLK_I) begin
    if (axi_mwr) begin
      mem_r[w_word] <= wmerged;
    end else if (serve && in_range && LINK.mem_we) begin
      mem_r[m_word] <= LINK.mem_wdata;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ack_r    <= 1'b0;
      merr_r   <= 1'b0;
      mrdata_r <= 32'h00000000;
    end else begin
      ack_r    <= serve && in_range;
      merr_r   <= serve && !in_range;
      mrdata_r <= mem_r[m_word];
    end
  end

  // ****************************************
  // Done record, set wins over clear
  // ****************************************
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      done_rec_r <= '0;
    end else begin
      done_rec_r <= (done_rec_r &
                     ~((wr_go && w_rec) ? wdata_r[CH_N-1:0] : '0)) |
                    LINK.dma_done;
    end
  end

  // ****************************************
  // AXI4-Lite channels
  // ****************************************
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      aw_got_r <= 1'b0;
      awaddr_r <= 32'h00000000;
      w_got_r  <= 1'b0;
      wdata_r  <= 32'h00000000;
      wstrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= dma_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r  <= dma_pkg::RESP_OKAY;
      rdata_r  <= 32'h00000000;
    end else begin
      if (AWVALID_I && AWREADY_O) begin
        aw_got_r <= 1'b1;
        awaddr_r <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
        w_got_r <= 1'b1;
        wdata_r <= WDATA_I;
        wstrb_r <= WSTRB_I;
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= (w_dev || w_rec || w_mem) ? dma_pkg::RESP_OKAY :
                    dma_pkg::RESP_SLVERR;
      end else if (BREADY_I && bvalid_r) begin
        bvalid_r <= 1'b0;
      end
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rresp_r  <= (r_dev || r_rec || r_mem) ? dma_pkg::RESP_OKAY :
                    dma_pkg::RESP_SLVERR;
        rdata_r  <= r_dev ? LINK.reg_rdata :
                    r_rec ? 32'(done_rec_r) :
                    r_mem ? mem_r[r_word] : 32'h00000000;
      end else if (RREADY_I && rvalid_r) begin
        rvalid_r <= 1'b0;
      end
    end
  end

endmodule : dma_host_end

/* tb/dma_link_asserts.sv */
/* Assertions on the link between controller and host end.
   Assumes one clock; instantiated beside the link, no bind. */
`timescale 1ns/100ps
module dma_link_asserts #(parameter int CH_N = dma_pkg::CH_N) (
  input  wire logic            CLK_I,
  input  wire logic            RST_I,
  input  wire logic            reg_we,
  input  wire logic [2:0]      reg_addr,
  input  wire logic [31:0]     reg_wdata,
  input  wire logic [31:0]     reg_rdata,
  input  wire logic            mem_req,
  input  wire logic            mem_we,
  input  wire logic [31:0]     mem_addr,
  input  wire logic            mem_ack,
  input  wire logic            mem_err,
  input  wire logic [CH_N-1:0] dma_done,
  input  wire logic            dma_err
);
  // ******
  // Base copy
  // ******
  logic [23:0] base_r;
  wire         in_tbl = mem_req && (mem_addr[31:8] == base_r);
  wire         err_clr = reg_we && (reg_addr == dma_pkg::REG_ERR);
  always_ff @(posedge CLK_I) begin
    if (RST_I) base_r <= 24'h0;
    else if (reg_we && reg_addr == dma_pkg::REG_PRI_BASE)
      base_r <= reg_wdata[31:8];
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  AST_NO_FOURTH: assert property (in_tbl |->
    mem_addr[3:0] != dma_pkg::OFS_UNUSED) else $error("spare word hit");
  AST_PRI_WR_CFG: assert property (in_tbl && mem_we &&
    !mem_addr[7] |-> mem_addr[3:0] == dma_pkg::OFS_CFG)
    else $error("pointer written");
  AST_PRI_RD: assert property (reg_addr == dma_pkg::REG_PRI_BASE |->
    reg_rdata == {base_r, 8'h00}) else $error("primary base wrong");
  AST_ALT_RD: assert property (reg_addr == dma_pkg::REG_ALT_BASE |->
    reg_rdata == {base_r, dma_pkg::ALT_OFFSET}) else $error("alt base wrong");
  AST_DONE_ONE: assert property (|dma_done |=> dma_done == '0)
    else $error("done too long");
  AST_DONE_CAUSE: assert property (|dma_done |->
    $past(mem_ack && mem_we)) else $error("done without write ack");
  AST_ERR_SET: assert property (mem_err |=> dma_err)
    else $error("error not flagged");
  AST_ERR_HOLD: assert property (dma_err && !err_clr |=> dma_err)
    else $error("error dropped");
endmodule : dma_link_asserts

/* tb/dma_descriptor_table_and_error_tb.sv */
/* Bench: both ends joined, software traffic over AXI4-Lite.
   Assumes the package, link, both ends and checker compiled first. */
`timescale 1ns/100ps
`define CHK(N, X, G) begin compares++; if ((G) !== (X)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", N, X, G); end end
module dma_descriptor_table_and_error_tb;
  logic        clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rd, base, ent, lfsr;
  logic [31:0] sv [4];
  logic [7:0]  preq = '0;
  logic [1:0]  rsp;
  logic [2:0]  ch;
  wire         awready, wready, bvalid, arready, rvalid, err, act;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          n_errors = 0, compares = 0, cyc = 0, n;
  dma_link_if link();
  dma_device_end i_dma_device_end (.CLK_I(clk), .RST_I(rst), .LINK(link),
    .ACTIVE_O(act));
  dma_host_end i_dma_host_end (.CLK_I(clk), .RST_I(rst), .LINK(link),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
    .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid), .WREADY_O(wready),
    .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
    .PERIPH_REQ_I(preq), .ERR_O(err));
  dma_link_asserts i_dma_link_asserts (.CLK_I(clk), .RST_I(rst),
    .reg_we(link.reg_we), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
    .mem_req(link.mem_req), .mem_we(link.mem_we), .mem_addr(link.mem_addr),
    .mem_ack(link.mem_ack), .mem_err(link.mem_err),
    .dma_done(link.dma_done), .dma_err(link.dma_err));
  // ******
  // Clock, timeout, helpers
  // ******
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin n_errors++; end_sim(); end
  end
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nx
  function automatic logic [31:0] cfg(input logic [2:0] m, input int k, r);
    return {14'h0, r[3:0], 10'(k - 1), 1'b0, m};
  endfunction : cfg
  function automatic logic [31:0] ra(input int i);
    return 32'h1000 + 32'(4 * i);
  endfunction : ra
  task automatic wr(input logic [31:0] a, d);
    bit ta = 0, td = 0;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    while (!(ta && td)) begin
      @(posedge clk);
      if (!ta && awready) begin ta = 1; awvalid <= 1'b0; end
      if (!td && wready) begin td = 1; wvalid <= 1'b0; end
    end
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    rsp = bresp; bready <= 1'b0;
  endtask : wr
  task automatic rdt(input logic [31:0] a);
    araddr <= a; arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0; rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata; rsp = rresp; rready <= 1'b0;
  endtask : rdt
  task automatic run(input logic [2:0] c, input int i, b);
    wr(ra(dma_pkg::REG_CHEN_SET), 32'h1 << c);
    preq[c] <= 1'b1;
    rd = '0;
    while (rd[b] !== 1'b1) rdt(ra(i));
    preq[c] <= 1'b0;
  endtask : run
  task automatic end_sim;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  // ******
  // Scenarios
  // ******
  initial begin
    lfsr = 32'h0001712F;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdt(ra(dma_pkg::REG_ALT_BASE));
    `CHK("alt base", 32'h80, rd)
    rdt(32'h1024);
    `CHK("unmapped", dma_pkg::RESP_SLVERR, rsp)
    lfsr = nx(lfsr);
    base = 32'h100 * (32'h1 + lfsr % 32'h3);
    wr(ra(dma_pkg::REG_PRI_BASE), base | 32'h5A);
    `CHK("bresp", dma_pkg::RESP_OKAY, rsp)
    rdt(ra(dma_pkg::REG_PRI_BASE));
    `CHK("pri base", base, rd)
    rdt(ra(dma_pkg::REG_ALT_BASE));
    `CHK("alt base", base | 32'h80, rd)
    ch = lfsr[4:2];
    n = 1 + int'(lfsr[6:5]);
    ent = base + {ch, 4'h0};
    wr(ent, 32'h800 + 4 * (n - 1));
    wr(ent + 4, 32'hA00 + 4 * (n - 1));
    wr(ent + 8, cfg(dma_pkg::MODE_BASIC, n, 10));
    wr(ent + 12, 32'h5A5AA5A5);
    for (int i = 0; i < n; i++) begin
      lfsr = nx(lfsr);
      sv[i] = lfsr;
      wr(32'h800 + 4 * i, lfsr);
    end
    run(ch, dma_pkg::IDX_DONE_REC, ch);
    for (int i = 0; i < n; i++) begin
      rdt(32'hA00 + 4 * i);
      `CHK("dst", sv[i], rd)
    end
    rdt(ent);
    `CHK("src ptr", 32'h800 + 4 * (n - 1), rd)
    rdt(ent + 4);
    `CHK("dst ptr", 32'hA00 + 4 * (n - 1), rd)
    rdt(ent + 8);
    `CHK("mode", dma_pkg::MODE_STOP, rd[2:0])
    rdt(ent + 12);
    `CHK("spare", 32'h5A5AA5A5, rd)
    rdt(ra(dma_pkg::REG_CHEN_SET));
    `CHK("enables", 32'h0, rd)
    wr(ra(dma_pkg::IDX_DONE_REC), 32'hFF);
    wr(ra(dma_pkg::REG_CHEN_SET), 32'h1 << ch);
    preq[ch] <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("busy", 1'b1, act)
    repeat (12) @(posedge clk);
    preq[ch] <= 1'b0;
    rdt(ra(dma_pkg::REG_CHEN_SET));
    `CHK("stop enables", 32'h0, rd)
    rdt(ra(dma_pkg::IDX_DONE_REC));
    `CHK("stop done", 32'h0, rd)
    ch = ch ^ 3'h1;
    ent = base + {ch, 4'h0};
    wr(ent, 32'h61C);
    wr(ent + 4, 32'h0);
    wr(ent + 8, cfg(dma_pkg::MODE_PSG_PRI, 8, 2));
    for (int i = 0; i < 2; i++) begin
      lfsr = nx(lfsr);
      sv[i] = lfsr;
      wr(32'hC00 + 4 * i, lfsr);
      wr(32'h600 + 16 * i, 32'hC00 + 4 * i);
      wr(32'h604 + 16 * i, 32'hD00 + 4 * i);
      wr(32'h608 + 16 * i, cfg(i ? dma_pkg::MODE_BASIC
                               : dma_pkg::MODE_PSG_ALT, 1, 10));
    end
    run(ch, dma_pkg::IDX_DONE_REC, ch);
    for (int i = 0; i < 2; i++) begin
      rdt(32'hD00 + 4 * i);
      `CHK("task dst", sv[i], rd)
    end
    rdt(ent + 8);
    `CHK("pri mode", dma_pkg::MODE_STOP, rd[2:0])
    rdt(ra(dma_pkg::IDX_DONE_REC));
    `CHK("done rec", 32'h1 << ch, rd)
    wr(ra(dma_pkg::IDX_DONE_REC), 32'hFF);
    ch = ch ^ 3'h2;
    ent = base + {ch, 4'h0};
    wr(ent, 32'h10000);
    wr(ent + 8, cfg(dma_pkg::MODE_BASIC, 1, 10));
    run(ch, dma_pkg::REG_ERR, 0);
    `CHK("err pin", 1'b1, err)
    rdt(ra(dma_pkg::REG_CHEN_SET));
    `CHK("enables", 32'h0, rd)
    rdt(ra(dma_pkg::IDX_DONE_REC));
    `CHK("done rec", 32'h0, rd)
    wr(ra(dma_pkg::REG_ERR), 32'h0);
    `CHK("err pin", 1'b0, err)
    `CHK("idle", 1'b0, act)
    end_sim();
  end
endmodule : dma_descriptor_table_and_error_tb
